// ---- sdpci_cmd_if.sv ----
// Decoded command carrier between decoder and the core.
// Assumes one clock domain.
interface sdpci_cmd_if;
  logic              valid;
  sdpci_pkg::sdpci_cmd_t code;
  logic [1:0]        bank;
  logic [11:0]       addr;
  modport src (output valid, output code, output bank, output addr);
  modport dst (input valid, input code, input bank, input addr);
endinterface

// ---- sdpci_core.sv ----
// Bank state, burst engine, masking and power state of the memory.
// Assumes the controller keeps its own timing and tie-offs.
`include "sdpci_regs.svh"
module sdpci_core (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  // Pins
  input  wire logic        clock_gate_in,
  input  wire logic        device_select_n_in,
  input  wire logic        row_strobe_n_in,
  input  wire logic        column_strobe_n_in,
  input  wire logic        write_cmd_n_in,
  input  wire logic [1:0]  bank_select_in,
  input  wire logic [11:0] addr_in,
  input  wire logic        low_byte_mask_in,
  input  wire logic        high_byte_mask_in,
  input  wire logic [15:0] dq_in,
  input  wire logic [1:0]  org_in,
  // Data outputs
  output logic [15:0]      dq_out,
  output logic [15:0]      dq_oe_out,
  // Status
  output logic [3:0]       bank_open_out,
  output logic [1:0]       power_state_out,
  output logic [11:0]      mode_out,
  output logic             wr_strobe_out,
  output logic [15:0]      wr_data_out,
  output logic [15:0]      wr_lane_en_out,
  output logic [1:0]       wr_bank_out,
  output logic [9:0]       wr_col_out
);
  sdpci_cmd_if cmd();
  sdpci_pkg::sdpci_state_e state_reg, state_next;
  logic [11:0] row_reg [4];
  logic [3:0]  open_reg;
  logic [11:0] mode_reg;
  logic [9:0]  col_reg;
  logic [1:0]  bank_reg;
  logic [3:0]  left_reg;
  logic        wr_reg, rd_reg, auto_pre_reg;
  logic [2:0]  lat_reg;
  logic [1:0]  dqm_d1_reg, dqm_d2_reg;
  logic [15:0] dq_reg;

  // Command inputs are seen only while running with the clock gated on.
  wire awake_w = (state_reg == sdpci_pkg::SDPCI_ST_RUN) && clock_gate_in;

  sdpci_decoder u_dec (
    .ref_clk_in         (ref_clk_in),
    .srst_in            (srst_in),
    .sample_in          (awake_w),
    .device_select_n_in (device_select_n_in),
    .row_strobe_n_in    (row_strobe_n_in),
    .column_strobe_n_in (column_strobe_n_in),
    .write_cmd_n_in     (write_cmd_n_in),
    .bank_select_in     (bank_select_in),
    .addr_in            (addr_in),
    .cmd                (cmd)
  );

  function automatic logic [9:0] col_of(input logic [11:0] a,
                                        input logic [1:0] org);
    case (org)
      `SDPCI_ORG_X4: col_of = a[9:0];
      `SDPCI_ORG_X8: col_of = {1'b0, a[8:0]};
      default:       col_of = {2'b00, a[7:0]};
    endcase
  endfunction

  function automatic logic [15:0] width_mask(input logic [1:0] org);
    case (org)
      `SDPCI_ORG_X4: width_mask = 16'h000F;
      `SDPCI_ORG_X8: width_mask = 16'h00FF;
      default:       width_mask = 16'hFFFF;
    endcase
  endfunction

  // Narrow parts use only the upper mask pin.
  wire [1:0] dqm_w = (org_in == `SDPCI_ORG_X16) ?
    {high_byte_mask_in, low_byte_mask_in} :
    {high_byte_mask_in, high_byte_mask_in};
  wire [15:0] lane_w = {{8{~dqm_w[1]}}, {8{~dqm_w[0]}}} &
                       width_mask(org_in);
  wire is_act_w = cmd.valid && cmd.code == `SDPCI_CMD_ACT;
  wire is_rd_w  = cmd.valid && cmd.code == `SDPCI_CMD_RD;
  wire is_wr_w  = cmd.valid && cmd.code == `SDPCI_CMD_WR;
  wire is_pre_w = cmd.valid && cmd.code == `SDPCI_CMD_PRE;
  wire is_lmr_w = cmd.valid && cmd.code == `SDPCI_CMD_LMR;
  wire is_ref_w = cmd.valid && cmd.code == `SDPCI_CMD_REF;
  wire is_bst_w = cmd.valid && cmd.code == `SDPCI_CMD_BST;
  wire busy_w   = wr_reg || rd_reg;
  wire [3:0] burst_len_w = 4'h1 << mode_reg[`SDPCI_BL_LSB +: 2];
  wire [2:0] cas_lat_w   = mode_reg[`SDPCI_CL_LSB +: 3];
  // Clock gate is sampled synchronously while running, and likewise on the
  // rising edge to wake from the low-power states.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sdpci_pkg::SDPCI_ST_RUN:
        if (!clock_gate_in) begin
          if (busy_w)
            state_next = sdpci_pkg::SDPCI_ST_SUSPEND;
          else if (open_reg != 4'h0 || !(is_ref_w))
            state_next = sdpci_pkg::SDPCI_ST_PDOWN;
          else
            state_next = sdpci_pkg::SDPCI_ST_SREF;
        end
      sdpci_pkg::SDPCI_ST_SUSPEND,
      sdpci_pkg::SDPCI_ST_PDOWN,
      sdpci_pkg::SDPCI_ST_SREF:
        if (clock_gate_in)
          state_next = sdpci_pkg::SDPCI_ST_RUN;
      default: state_next = sdpci_pkg::SDPCI_ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) state_reg <= sdpci_pkg::SDPCI_ST_RUN;
    else         state_reg <= state_next;
  end

  // Bank rows and mode register; input buffers closed unless awake.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      open_reg <= 4'h0;
      mode_reg <= `SDPCI_MODE_RESET;
    end else begin
      if (is_act_w) begin
        open_reg[cmd.bank] <= 1'b1;
        row_reg[cmd.bank]  <= cmd.addr;
      end
      if (is_pre_w) begin
        if (cmd.addr[`SDPCI_PALL_BIT]) open_reg <= 4'h0;
        else open_reg[cmd.bank] <= 1'b0;
      end
      if (is_lmr_w) mode_reg <= cmd.addr;
      if (auto_pre_reg && busy_w && left_reg == 4'h1 && awake_w)
        open_reg[bank_reg] <= 1'b0;
    end
  end

  // Burst engine runs whether or not select is held high.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      left_reg <= 4'h0;
      auto_pre_reg <= 1'b0;
      col_reg <= 10'h000;
      bank_reg <= 2'h0;
    end else if (is_rd_w || is_wr_w) begin
      wr_reg <= is_wr_w;
      rd_reg <= is_rd_w;
      left_reg <= burst_len_w;
      col_reg <= col_of(cmd.addr, org_in);
      bank_reg <= cmd.bank;
      auto_pre_reg <= cmd.addr[`SDPCI_PALL_BIT];
    end else if (is_bst_w) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      left_reg <= 4'h0;
    end else if (busy_w && awake_w) begin
      left_reg <= left_reg - 4'h1;
      col_reg  <= col_reg + 10'h001;
      if (left_reg == 4'h1) begin
        wr_reg <= 1'b0;
        rd_reg <= 1'b0;
      end
    end
  end

  // Read data latency and the two-clock mask pipeline.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      lat_reg    <= 3'h0;
      dqm_d1_reg <= 2'h3;
      dqm_d2_reg <= 2'h3;
      dq_reg     <= 16'h0000;
    end else begin
      lat_reg    <= (rd_reg && awake_w) ? cas_lat_w : lat_reg -
                    {2'b00, lat_reg != 3'h0};
      dqm_d1_reg <= rd_reg ? dqm_w : 2'h3;
      dqm_d2_reg <= dqm_d1_reg;
      dq_reg     <= {bank_reg, col_reg, 4'h0} ^ {4'h0, row_reg[bank_reg]};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wr_strobe_out  <= 1'b0;
      wr_data_out    <= 16'h0000;
      wr_lane_en_out <= 16'h0000;
      wr_bank_out    <= 2'h0;
      wr_col_out     <= 10'h000;
    end else begin
      wr_strobe_out  <= wr_reg && awake_w;
      wr_data_out    <= dq_in & lane_w;
      wr_lane_en_out <= lane_w;
      wr_bank_out    <= bank_reg;
      wr_col_out     <= col_reg;
    end
  end

  assign dq_out = dq_reg;
  assign dq_oe_out = (lat_reg != 3'h0) ?
    ({{8{~dqm_d2_reg[1]}}, {8{~dqm_d2_reg[0]}}} & width_mask(org_in)) :
    16'h0000;
  assign bank_open_out   = open_reg;
  assign power_state_out = state_reg;
  assign mode_out        = mode_reg;

  property p_pall;
    @(posedge ref_clk_in) disable iff (srst_in)
      is_pre_w && cmd.addr[`SDPCI_PALL_BIT] |=> open_reg == 4'h0;
  endproperty
  a_pall: assert property (p_pall) else $error("Precharge all failed");
  property p_act;
    @(posedge ref_clk_in) disable iff (srst_in)
      is_act_w |=> open_reg[$past(cmd.bank)];
  endproperty
  a_act: assert property (p_act) else $error("Activate failed");
  property p_lmr;
    @(posedge ref_clk_in) disable iff (srst_in)
      is_lmr_w |=> mode_reg == $past(cmd.addr);
  endproperty
  a_lmr: assert property (p_lmr) else $error("Mode load failed");
  property p_desel;
    @(posedge ref_clk_in) disable iff (srst_in)
      device_select_n_in && awake_w |=> !cmd.valid;
  endproperty
  a_desel: assert property (p_desel) else $error("Command not ignored");
  property p_mask;
    @(posedge ref_clk_in) disable iff (srst_in)
      wr_reg && awake_w && dqm_w[0] |=> wr_data_out[7:0] == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("Masked lane written");
  property p_rdz;
    @(posedge ref_clk_in) disable iff (srst_in)
      rd_reg && dqm_w == 2'h3 ##1 1'b1 |=> dq_oe_out == 16'h0000;
  endproperty
  a_rdz: assert property (p_rdz) else $error("Read mask late");
  property p_sleep;
    @(posedge ref_clk_in) disable iff (srst_in)
      state_reg != sdpci_pkg::SDPCI_ST_RUN |=> !cmd.valid;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Buffers not off");
  property p_susp;
    @(posedge ref_clk_in) disable iff (srst_in)
      state_reg == sdpci_pkg::SDPCI_ST_RUN && !clock_gate_in && busy_w
      |=> state_reg == sdpci_pkg::SDPCI_ST_SUSPEND;
  endproperty
  a_susp: assert property (p_susp) else $error("Suspend missed");
  property p_burst;
    @(posedge ref_clk_in) disable iff (srst_in)
      busy_w && awake_w && !cmd.valid && left_reg > 4'h1
      |=> busy_w && left_reg == $past(left_reg) - 4'h1;
  endproperty
  a_burst: assert property (p_burst) else $error("Burst stalled");
  c_act: cover property (@(posedge ref_clk_in) is_act_w);
  c_wr:  cover property (@(posedge ref_clk_in) wr_strobe_out);
  c_pd:  cover property (@(posedge ref_clk_in)
    state_reg == sdpci_pkg::SDPCI_ST_PDOWN);
endmodule // sdpci_core

// ---- sdpci_ctrl_model.sv ----
// Memory controller model that drives the command and data pins.
// Assumes the memory samples its pins on the rising edge of ref_clk_in.
module sdpci_ctrl_model (
  // Clock
  input  wire logic ref_clk_in,
  // Pins driven towards the memory
  output logic        gate_out,
  output logic        sel_n_out,
  output logic [2:0]  code_out,
  output logic [1:0]  bank_out,
  output logic [11:0] addr_out,
  output logic        lmask_out,
  output logic        hmask_out,
  output logic [15:0] dq_out
);
  initial begin
    gate_out  = 1'b1;
    sel_n_out = 1'b1;
    code_out  = 3'h7;
    bank_out  = 2'h0;
    addr_out  = 12'h000;
    lmask_out = 1'b0;
    hmask_out = 1'b0;
    dq_out    = 16'h0000;
  end
  // Released address and data show the inverse of their last value; select and code go idle, bank keeps its value.
  task automatic issue(input logic sel_n, input logic [3:0] code,
                       input logic [1:0] bank, input logic [11:0] addr,
                       input logic [15:0] data);
    @(negedge ref_clk_in);
    sel_n_out = sel_n;
    code_out  = code[2:0];
    bank_out  = bank;
    addr_out  = addr;
    dq_out    = data;
    @(negedge ref_clk_in);
    sel_n_out = 1'b1;
    code_out  = 3'h7;
    addr_out  = ~addr;
    dq_out    = ~data;
  endtask
  task automatic set_pins(input logic gate, input logic lm, input logic hm);
    @(negedge ref_clk_in);
    gate_out  = gate;
    lmask_out = lm;
    hmask_out = hm;
  endtask
  // Write data must stand at the edge on which the memory takes the beat.
  task automatic put_data(input logic [15:0] data);
    @(negedge ref_clk_in);
    dq_out = data;
  endtask
  // Drops the clock gate right behind the command, so that the gate is
  // seen low on the edge after the one at which the decoder takes the command.
  task automatic issue_then_sleep(input logic [3:0] code);
    @(negedge ref_clk_in);
    sel_n_out = 1'b0;
    code_out  = code[2:0];
    @(negedge ref_clk_in);
    sel_n_out = 1'b1;
    code_out  = 3'h7;
    gate_out  = 1'b0;
  endtask
endmodule // sdpci_ctrl_model

// ---- sdpci_decoder.sv ----
// Command decoder: registers the strobes and qualifies them by select.
// Assumes inputs synchronous to ref_clk_in.
`include "sdpci_regs.svh"
module sdpci_decoder (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  // Pins as sampled
  input  wire logic        sample_in,
  input  wire logic        device_select_n_in,
  input  wire logic        row_strobe_n_in,
  input  wire logic        column_strobe_n_in,
  input  wire logic        write_cmd_n_in,
  input  wire logic [1:0]  bank_select_in,
  input  wire logic [11:0] addr_in,
  // Decoded command
  sdpci_cmd_if.src         cmd
);
  wire sdpci_pkg::sdpci_cmd_t code_w =
    {1'b0, row_strobe_n_in, column_strobe_n_in, write_cmd_n_in};
  wire take_w = sample_in && !device_select_n_in;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cmd.valid <= 1'b0;
      cmd.code  <= `SDPCI_CMD_NOP;
    end else begin
      cmd.valid <= take_w && (code_w != `SDPCI_CMD_NOP);
      cmd.code  <= code_w;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    cmd.bank <= bank_select_in;
    cmd.addr <= addr_in;
  end
endmodule // sdpci_decoder

// ---- sdpci_pkg.sv ----
// Types shared by the SDRAM pin command interface modules.
// Assumes nothing of its surroundings.
package sdpci_pkg;
  typedef enum logic [1:0] {
    SDPCI_ST_RUN,
    SDPCI_ST_SUSPEND,
    SDPCI_ST_PDOWN,
    SDPCI_ST_SREF
  } sdpci_state_e;
  typedef logic [3:0] sdpci_cmd_t;
endpackage

// ---- sdpci_regs.svh ----
// Constants of the SDRAM pin command interface: command codes, field positions,
// mode and timing counts. Assumes inclusion by bare name from design files.
// Function
// - Inputs sampled only on rising clock edge.
// - Every edge advances burst counter, output registers; burst counter holds unless running with clock gate high.
// - Clock gate low enters power-down, refresh or suspend.
// - Clock gate synchronous except inside power-down modes; code samples it on the rising edge in every state.
// - Power-down modes disable input buffers, clock included.
// - Select low enables decoder; high ignores commands.
// - Bursts continue and masks act while deselected.
// - Four strobes together encode the command.
// - Masked byte lanes discard write data.
// - Read mask floats outputs two clocks later.
// - Low mask lower byte, high mask upper byte.
// - Bank select picks bank for bank commands.
// - Row twelve bits; column by organisation; auto precharge.
// - Precharge with all bit closes every bank.
// - Mode register loaded from address inputs.
// - Data width sixteen, eight or four bits.
`ifndef SDPCI_REGS_SVH
`define SDPCI_REGS_SVH
`define SDPCI_CMD_LMR     4'h0
`define SDPCI_CMD_REF     4'h1
`define SDPCI_CMD_PRE     4'h2
`define SDPCI_CMD_ACT     4'h3
`define SDPCI_CMD_WR      4'h4
`define SDPCI_CMD_RD      4'h5
`define SDPCI_CMD_BST     4'h6
`define SDPCI_CMD_NOP     4'h7
`define SDPCI_PALL_BIT    10
`define SDPCI_BL_LSB      0
`define SDPCI_CL_LSB      4
`define SDPCI_MODE_RESET  12'h022
`define SDPCI_MASK_LAT    2
`define SDPCI_ORG_X16     2'h2
`define SDPCI_ORG_X8      2'h1
`define SDPCI_ORG_X4      2'h0
`endif

// ---- sdram_pin_command_interface_bench.sv ----
// Self-checking bench for the memory core, fed by the controller model.
// Assumes the organisation changes only while the memory is idle.
`include "sdpci_regs.svh"
module sdram_pin_command_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in;
  logic        srst_in;
  logic        gate, sel_n, lm, hm;
  logic [2:0]  code;
  logic [1:0]  bank;
  logic [11:0] addr;
  logic [15:0] dqw;
  logic [15:0] dq_o, dq_oe, wr_data, wr_lane;
  logic [3:0]  bank_open;
  logic [1:0]  pstate, wr_bank;
  logic [11:0] mode;
  logic [1:0]  org;
  logic        wr_strobe;
  logic [9:0]  wr_col;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  sdpci_ctrl_model u_sdpci_ctrl_model (.ref_clk_in(ref_clk_in),
    .gate_out(gate), .sel_n_out(sel_n), .code_out(code), .bank_out(bank),
    .addr_out(addr), .lmask_out(lm), .hmask_out(hm), .dq_out(dqw));
  sdpci_core u_sdpci_core (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .clock_gate_in(gate), .device_select_n_in(sel_n),
    .row_strobe_n_in(code[2]), .column_strobe_n_in(code[1]),
    .write_cmd_n_in(code[0]), .bank_select_in(bank), .addr_in(addr),
    .low_byte_mask_in(lm), .high_byte_mask_in(hm), .dq_in(dqw),
    .org_in(org), .dq_out(dq_o), .dq_oe_out(dq_oe),
    .bank_open_out(bank_open), .power_state_out(pstate), .mode_out(mode),
    .wr_strobe_out(wr_strobe), .wr_data_out(wr_data),
    .wr_lane_en_out(wr_lane), .wr_bank_out(wr_bank), .wr_col_out(wr_col));
  task automatic summarize();
    $display("compared %0d, mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input logic s, input logic [3:0] c, input logic [1:0] b,
                     input logic [11:0] a, input logic [15:0] d);
    u_sdpci_ctrl_model.issue(s, c, b, a, d);
    repeat (2) @(negedge ref_clk_in);
  endtask
  task automatic t_reset();
    chk({12'h000, bank_open}, 16'h0000, "banks after reset");
    chk({4'h0, mode}, 16'h0022, "mode after reset");
    chk({14'h0, pstate}, 16'h0000, "state after reset");
    chk(dq_oe, 16'h0000, "drive after reset");
  endtask
  task automatic t_banks();
    cmd(1'b0, `SDPCI_CMD_ACT, 2'h1, 12'hABC, 16'h0000);
    chk({12'h000, bank_open}, 16'h0002, "activate bank 1");
    cmd(1'b1, `SDPCI_CMD_ACT, 2'h2, 12'h123, 16'h0000);
    chk({12'h000, bank_open}, 16'h0002, "deselected activate");
    cmd(1'b0, `SDPCI_CMD_ACT, 2'h3, 12'hFFF, 16'h0000);
    cmd(1'b0, `SDPCI_CMD_PRE, 2'h1, 12'h000, 16'h0000);
    chk({12'h000, bank_open}, 16'h0008, "precharge one bank");
    cmd(1'b0, `SDPCI_CMD_ACT, 2'h0, 12'h001, 16'h0000);
    cmd(1'b0, `SDPCI_CMD_PRE, 2'h0, 12'h400, 16'h0000);
    chk({12'h000, bank_open}, 16'h0000, "precharge all");
  endtask
  task automatic t_mode_write();
    cmd(1'b0, `SDPCI_CMD_LMR, 2'h0, 12'h030, 16'h0000);
    chk({4'h0, mode}, 16'h0030, "mode load");
    cmd(1'b0, `SDPCI_CMD_ACT, 2'h2, 12'h055, 16'h0000);
    u_sdpci_ctrl_model.set_pins(1'b1, 1'b1, 1'b0);
    u_sdpci_ctrl_model.issue(1'b0, `SDPCI_CMD_WR, 2'h2, 12'h1A5, 16'hBEEF);
    u_sdpci_ctrl_model.put_data(16'hBEEF);
    for (int i = 0; i < 8 && wr_strobe !== 1'b1; i++)
      @(negedge ref_clk_in);
    chk({15'h0, wr_strobe}, 16'h0001, "write beat");
    chk(wr_lane, 16'hFF00, "low lane masked");
    chk(wr_data, 16'hBE00, "upper byte");
    chk({6'h0, wr_col}, 16'h00A5, "column");
    chk({14'h0, wr_bank}, 16'h0002, "write bank");
  endtask
  task automatic t_read_mask();
    u_sdpci_ctrl_model.set_pins(1'b1, 1'b0, 1'b1);
    u_sdpci_ctrl_model.issue(1'b0, `SDPCI_CMD_RD, 2'h2, 12'h010, 16'h0000);
    for (int i = 0; i < 8 && dq_oe === 16'h0000; i++)
      @(negedge ref_clk_in);
    chk(dq_oe, 16'h00FF, "upper byte floats");
    u_sdpci_ctrl_model.set_pins(1'b1, 1'b0, 1'b0);
    cmd(1'b0, `SDPCI_CMD_PRE, 2'h0, 12'h400, 16'h0000);
  endtask
  task automatic t_power();
    u_sdpci_ctrl_model.set_pins(1'b0, 1'b0, 1'b0);
    repeat (3) @(negedge ref_clk_in);
    chk({14'h0, pstate}, 16'h0002, "power-down entry");
    cmd(1'b0, `SDPCI_CMD_ACT, 2'h1, 12'h000, 16'h0000);
    chk({12'h000, bank_open}, 16'h0000, "ignored in power-down");
    u_sdpci_ctrl_model.set_pins(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 8 && pstate !== 2'h0; i++)
      @(negedge ref_clk_in);
    chk({14'h0, pstate}, 16'h0000, "power-down exit");
  endtask
  task automatic t_narrow();
    org = `SDPCI_ORG_X8;
    u_sdpci_ctrl_model.set_pins(1'b1, 1'b1, 1'b0);
    u_sdpci_ctrl_model.issue(1'b0, `SDPCI_CMD_WR, 2'h2, 12'h1A5, 16'hBEEF);
    u_sdpci_ctrl_model.put_data(16'hBEEF);
    @(negedge ref_clk_in);
    chk({15'h0, wr_strobe}, 16'h0001, "narrow write beat");
    chk(wr_lane, 16'h00FF, "narrow lanes");
    chk(wr_data, 16'h00EF, "narrow data");
    chk({6'h0, wr_col}, 16'h01A5, "narrow column");
    org = `SDPCI_ORG_X16;
  endtask
  task automatic t_sleep();
    u_sdpci_ctrl_model.issue_then_sleep(`SDPCI_CMD_REF);
    repeat (2) @(negedge ref_clk_in);
    chk({14'h0, pstate}, 16'h0003, "self refresh entry");
    u_sdpci_ctrl_model.set_pins(1'b1, 1'b0, 1'b0);
    @(negedge ref_clk_in);
    chk({14'h0, pstate}, 16'h0000, "self refresh exit");
  endtask
  task automatic t_burst();
    cmd(1'b0, `SDPCI_CMD_LMR, 2'h0, 12'h031, 16'h0000);
    cmd(1'b0, `SDPCI_CMD_ACT, 2'h1, 12'h077, 16'h0000);
    u_sdpci_ctrl_model.set_pins(1'b1, 1'b0, 1'b0);
    u_sdpci_ctrl_model.issue(1'b0, `SDPCI_CMD_WR, 2'h1, 12'h4F0, 16'h1234);
    u_sdpci_ctrl_model.put_data(16'h1234);
    @(negedge ref_clk_in);
    chk({15'h0, wr_strobe}, 16'h0001, "first beat");
    chk({6'h0, wr_col}, 16'h00F0, "first beat column");
    chk(wr_data, 16'h1234, "first beat data");
    @(negedge ref_clk_in);
    chk({15'h0, wr_strobe}, 16'h0001, "second beat deselected");
    chk({6'h0, wr_col}, 16'h00F1, "second beat column");
    chk({12'h000, bank_open}, 16'h0000, "auto precharge");
    @(negedge ref_clk_in);
    chk({15'h0, wr_strobe}, 16'h0000, "burst of two ends");
  endtask
  task automatic t_suspend();
    cmd(1'b0, `SDPCI_CMD_LMR, 2'h0, 12'h033, 16'h0000);
    u_sdpci_ctrl_model.issue(1'b0, `SDPCI_CMD_RD, 2'h0, 12'h000, 16'h0000);
    u_sdpci_ctrl_model.set_pins(1'b0, 1'b0, 1'b0);
    @(negedge ref_clk_in);
    chk({14'h0, pstate}, 16'h0001, "clock suspend entry");
    u_sdpci_ctrl_model.set_pins(1'b1, 1'b0, 1'b0);
    @(negedge ref_clk_in);
    chk({14'h0, pstate}, 16'h0000, "clock suspend exit");
    cmd(1'b0, `SDPCI_CMD_BST, 2'h0, 12'h000, 16'h0000);
    repeat (2) @(negedge ref_clk_in);
    chk(dq_oe, 16'h0000, "burst stop floats bus");
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    org     = `SDPCI_ORG_X16;
    srst_in = 1'b1;
    repeat (20) @(negedge ref_clk_in);
    srst_in = 1'b0;
    @(negedge ref_clk_in);
    t_reset();
    t_banks();
    t_mode_write();
    t_narrow();
    t_read_mask();
    t_power();
    t_sleep();
    t_burst();
    t_suspend();
    summarize();
  end
endmodule // sdram_pin_command_interface_bench
